// *** opcode_decode_pkg.sv ***
// constants, register map and opcode classes of the opcode decoder
`default_nettype none
package opcode_decode_pkg;
  localparam int WORD_W = 10;
  localparam int NIB_W  = 4;
  localparam int HIGH_W = 6;

  // first-word opcodes
  localparam logic [9:0] OP_NOP       = 10'h000;
  localparam logic [9:0] OP_SYS_RESET = 10'h001;
  localparam logic [9:0] OP_CLK_OP    = 10'h002;
  localparam logic [9:0] OP_WAKE_SKIP = 10'h003;
  localparam logic [9:0] OP_RAM_BKUP  = 10'h008;
  localparam logic [9:0] OP_PD_ARM    = 10'h05b;
  localparam logic [9:0] OP_HB_CLR    = 10'h058;
  localparam logic [9:0] OP_HB_SET    = 10'h059;
  localparam logic [9:0] OP_CLK_MODE  = 10'h216;
  localparam logic [9:0] OP_CLK_SEL   = 10'h209;
  localparam logic [9:0] OP_WDT_CLR   = 10'h2a0;
  localparam logic [9:0] OP_WDT_ARM   = 10'h29c;
  localparam logic [9:0] OP_LVD_KEEP  = 10'h293;
  localparam logic [9:0] OP_JMP_IND   = 10'h010;
  localparam logic [9:0] OP_CALL_IND  = 10'h030;
  localparam logic [9:0] OP_SEA       = 10'h025;
  localparam logic [9:0] OP_PORTD     = 10'h024;
  // high six-bit blocks
  localparam logic [5:0] HI_TABLE_LO  = 6'h08;
  localparam logic [5:0] HI_TABLE_HI  = 6'h0b;
  localparam logic [5:0] HI_TABLE_BIG = 6'h0a;
  localparam logic [5:0] HI_CALL_LO   = 6'h0c;
  localparam logic [5:0] HI_CALL_HI   = 6'h0d;
  localparam logic [5:0] HI_JMP_LO    = 6'h0e;
  localparam logic [5:0] HI_JMP_HI    = 6'h0f;
  localparam logic [5:0] HI_PCALL_LO  = 6'h10;
  localparam logic [5:0] HI_PCALL_HI  = 6'h17;
  localparam logic [5:0] HI_PJMP_LO   = 6'h18;
  localparam logic [5:0] HI_PJMP_HI   = 6'h1f;
  // second-word patterns
  localparam logic [5:0] SEA_W2_HI    = 6'h07;
  localparam logic [9:0] PORTD_W2     = 10'h02b;

  // register map
  localparam logic [3:0] REG_CONFIG   = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h4;
  localparam logic [3:0] REG_CLOCK    = 4'h8;
  localparam logic [3:0] REG_LAST     = 4'hc;
  localparam int CFG_BIG_ROM_BIT      = 0;
  localparam int CFG_LVD_BIT          = 1;
  localparam logic [1:0] CONFIG_RESET = 2'h3;
  localparam logic [3:0] CLOCK_RESET  = 4'h0;
  localparam int ST_WDT_FLAG   = 0;
  localparam int ST_HB_FLAG    = 1;
  localparam int ST_PD_ARMED   = 2;
  localparam int ST_WDT_ARMED  = 3;
  localparam int ST_WDT_STOP   = 4;
  localparam int ST_LVD_KEEP   = 5;
  localparam int ST_SKIP       = 6;
  localparam int ST_SECOND     = 7;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum {
    CLS_NOP, CLS_SYS_RESET, CLS_CLK_OP, CLS_RAM_BKUP, CLS_PD_ARM, CLS_WAKE_SKIP,
    CLS_WDT_CLR, CLS_WDT_ARM, CLS_HB_CLR, CLS_HB_SET, CLS_LVD_KEEP, CLS_CLK_MODE,
    CLS_CLK_SEL, CLS_TABLE, CLS_PAGE_CALL, CLS_PAGE_JMP, CLS_LONG_JMP, CLS_LONG_CALL,
    CLS_JMP_IND, CLS_CALL_IND, CLS_SEA, CLS_PORTD
  } op_class_t;

  function automatic logic is_two_word(input op_class_t c);
    is_two_word = (c == CLS_LONG_JMP) || (c == CLS_LONG_CALL) || (c == CLS_JMP_IND) ||
                  (c == CLS_CALL_IND) || (c == CLS_SEA) || (c == CLS_PORTD);
  endfunction
endpackage
`default_nettype wire

// *** opcode_classify.sv ***
// first-word opcode classifier
`default_nettype none
module opcode_classify (
  // instruction
  input  wire logic [opcode_decode_pkg::WORD_W-1:0] word,
  // variant options
  input  wire logic                                  big_rom,
  input  wire logic                                  lvd_present,
  // result
  output opcode_decode_pkg::op_class_t               cls
);
  import opcode_decode_pkg::*;

  logic [HIGH_W-1:0] hi;

  assign hi = word[9:4];

  always_comb begin
    cls = CLS_NOP;
    case (word)
      OP_NOP:       cls = CLS_NOP;
      OP_SYS_RESET: cls = CLS_SYS_RESET;
      OP_CLK_OP:    cls = CLS_CLK_OP;
      OP_WAKE_SKIP: cls = CLS_WAKE_SKIP;
      OP_RAM_BKUP:  cls = CLS_RAM_BKUP;
      OP_PD_ARM:    cls = CLS_PD_ARM;
      OP_HB_CLR:    cls = CLS_HB_CLR;
      OP_HB_SET:    cls = CLS_HB_SET;
      OP_CLK_MODE:  cls = CLS_CLK_MODE;
      OP_CLK_SEL:   cls = CLS_CLK_SEL;
      OP_WDT_CLR:   cls = CLS_WDT_CLR;
      OP_WDT_ARM:   cls = CLS_WDT_ARM;
      OP_LVD_KEEP:  cls = lvd_present ? CLS_LVD_KEEP : CLS_NOP;
      OP_JMP_IND:   cls = CLS_JMP_IND;
      OP_CALL_IND:  cls = CLS_CALL_IND;
      OP_SEA:       cls = CLS_SEA;
      OP_PORTD:     cls = CLS_PORTD;
      default: begin
        // blocks keyed by the high six bits
        if (hi >= HI_TABLE_LO && hi <= HI_TABLE_HI) begin
          if (big_rom || hi < HI_TABLE_BIG)
            cls = CLS_TABLE;
        end else if (hi >= HI_CALL_LO && hi <= HI_CALL_HI) begin
          cls = CLS_LONG_CALL;
        end else if (hi >= HI_JMP_LO && hi <= HI_JMP_HI) begin
          cls = CLS_LONG_JMP;
        end else if (hi >= HI_PCALL_LO && hi <= HI_PCALL_HI) begin
          cls = CLS_PAGE_CALL;
        end else if (hi >= HI_PJMP_LO && hi <= HI_PJMP_HI) begin
          cls = CLS_PAGE_JMP;
        end
      end
    endcase
  end
endmodule
`default_nettype wire

// *** cpu_opcode_decode_ctrl.sv ***
// opcode decoder for clock, power-down, watchdog and flag instructions, with AHB-Lite registers
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`default_nettype none
module cpu_opcode_decode_ctrl (
  // clock and reset
  input  wire logic                                  hclk,
  input  wire logic                                  hresetn,
  // AHB-Lite slave
  input  wire logic                                  hsel,
  input  wire logic [31:0]                           haddr,
  input  wire logic [1:0]                            htrans,
  input  wire logic                                  hwrite,
  input  wire logic [2:0]                            hsize,
  input  wire logic [31:0]                           hwdata,
  input  wire logic                                  hready,
  output logic      [31:0]                           hrdata,
  output logic                                       hreadyout,
  output logic                                       hresp,
  // instruction stream from program memory, with accumulator value and wake-up and watchdog flag inputs
  input  wire logic [opcode_decode_pkg::WORD_W-1:0]  instr_word,
  input  wire logic                                  instr_valid,
  input  wire logic [opcode_decode_pkg::NIB_W-1:0]   acc_value,
  input  wire logic                                  wakeup_flag,
  input  wire logic                                  watchdog_flag_set,
  // control results
  output logic                                       pc_inc,
  output logic      [opcode_decode_pkg::NIB_W-1:0]   clock_mode_reg,
  output logic      [opcode_decode_pkg::NIB_W-1:0]   clock_select_reg,
  output logic                                       enter_clock_operating_mode,
  output logic                                       enter_ram_backup_mode,
  output logic                                       software_system_reset,
  output logic                                       watchdog_flag,
  output logic                                       watchdog_stop,
  output logic                                       high_bit_ref_enable_flag,
  output logic                                       low_voltage_detect_keep,
  output logic                                       skip_next,
  // decoded branch, table and compare fields
  output logic                                       branch_valid,
  output logic                                       branch_call,
  output logic                                       branch_long,
  output logic      [6:0]                            branch_page,
  output logic      [6:0]                            branch_addr,
  output logic                                       table_ref_valid,
  output logic      [5:0]                            table_page,
  output logic                                       acc_compare_valid,
  output logic      [opcode_decode_pkg::NIB_W-1:0]   acc_compare_imm,
  output logic                                       port_d_skip_valid
);
  import opcode_decode_pkg::*;

  op_class_t cls;
  op_class_t first_cls_r;
  op_class_t first_cls_nxt;
  logic [1:0] config_r;
  logic [1:0] config_nxt;

  opcode_classify u_classify (
    .word        (instr_word),
    .big_rom     (config_r[CFG_BIG_ROM_BIT]),
    .lvd_present (config_r[CFG_LVD_BIT]),
    .cls         (cls)
  );

  // decoder state
  logic [NIB_W-1:0]  clk_mode_r, clk_mode_nxt, clk_sel_r, clk_sel_nxt;
  logic              pd_arm_r, pd_arm_nxt, wdt_arm_r, wdt_arm_nxt;
  logic              wdt_flag_r, wdt_flag_nxt, wdt_stop_r, wdt_stop_nxt;
  logic              hb_flag_r, hb_flag_nxt, lvd_r, lvd_nxt;
  logic              skip_r, skip_nxt, second_r, second_nxt, discard_r, discard_nxt;
  logic [4:0]        first_low_r, first_low_nxt;
  logic [WORD_W-1:0] last_r, last_nxt;
  logic              pc_inc_r, pc_inc_nxt, clk_op_r, clk_op_nxt, ram_r, ram_nxt;
  logic              sysrst_r, sysrst_nxt;
  logic              br_v_r, br_v_nxt, br_call_r, br_call_nxt, br_long_r, br_long_nxt;
  logic [6:0]        br_page_r, br_page_nxt, br_addr_r, br_addr_nxt;
  logic              tab_v_r, tab_v_nxt, cmp_v_r, cmp_v_nxt, pd_v_r, pd_v_nxt;
  logic [5:0]        tab_page_r, tab_page_nxt;
  logic [NIB_W-1:0]  cmp_imm_r, cmp_imm_nxt;

  // bus state
  logic              wr_pend_r, wr_pend_nxt;
  logic [3:0]        wr_addr_r, wr_addr_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic              bus_go;

  assign bus_go = hsel && hready && (htrans == HTRANS_NONSEQ);

  always_comb begin
    clk_mode_nxt  = clk_mode_r;
    clk_sel_nxt   = clk_sel_r;
    pd_arm_nxt    = pd_arm_r;
    wdt_arm_nxt   = wdt_arm_r;
    wdt_flag_nxt  = wdt_flag_r;
    wdt_stop_nxt  = wdt_stop_r;
    hb_flag_nxt   = hb_flag_r;
    lvd_nxt       = lvd_r;
    skip_nxt      = skip_r;
    second_nxt    = second_r;
    discard_nxt   = discard_r;
    first_cls_nxt = first_cls_r;
    first_low_nxt = first_low_r;
    last_nxt      = last_r;
    pc_inc_nxt    = 1'b0;
    clk_op_nxt    = 1'b0;
    ram_nxt       = 1'b0;
    sysrst_nxt    = 1'b0;
    br_v_nxt      = 1'b0;
    br_call_nxt   = br_call_r;
    br_long_nxt   = br_long_r;
    br_page_nxt   = br_page_r;
    br_addr_nxt   = br_addr_r;
    tab_v_nxt     = 1'b0;
    tab_page_nxt  = tab_page_r;
    cmp_v_nxt     = 1'b0;
    cmp_imm_nxt   = cmp_imm_r;
    pd_v_nxt      = 1'b0;
    if (instr_valid) begin
      pc_inc_nxt = 1'b1;
      last_nxt   = instr_word;
      if (second_r) begin
        second_nxt = 1'b0;
        if (!discard_r) begin
          case (first_cls_r)
            CLS_LONG_JMP, CLS_LONG_CALL: begin
              if (instr_word[9]) begin
                br_v_nxt    = 1'b1;
                br_long_nxt = 1'b1;
                br_call_nxt = (first_cls_r == CLS_LONG_CALL);
                br_page_nxt = {instr_word[8:7], first_low_r};
                br_addr_nxt = instr_word[6:0];
              end
            end
            CLS_JMP_IND, CLS_CALL_IND: begin
              // malformed second words fall back to no-operation
              if (instr_word[9] && instr_word[5:4] == 2'h0) begin
                br_v_nxt    = 1'b1;
                br_long_nxt = 1'b1;
                br_call_nxt = (first_cls_r == CLS_CALL_IND);
                br_page_nxt = {instr_word[8:6], instr_word[3:0]};
                br_addr_nxt = 7'h00;
              end
            end
            CLS_SEA: begin
              if (instr_word[9:4] == SEA_W2_HI) begin
                cmp_v_nxt   = 1'b1;
                cmp_imm_nxt = instr_word[3:0];
              end
            end
            CLS_PORTD: begin
              pd_v_nxt = (instr_word == PORTD_W2);
            end
            default: begin
            end
          endcase
        end
      end else if (skip_r) begin
        // a skipped two-word instruction also swallows its second word
        skip_nxt    = 1'b0;
        pd_arm_nxt  = 1'b0;
        wdt_arm_nxt = 1'b0;
        if (is_two_word(cls)) begin
          second_nxt  = 1'b1;
          discard_nxt = 1'b1;
        end
      end else begin
        pd_arm_nxt  = 1'b0;
        wdt_arm_nxt = 1'b0;
        case (cls)
          CLS_SYS_RESET: sysrst_nxt = 1'b1;
          CLS_CLK_OP:    clk_op_nxt = pd_arm_r;
          CLS_RAM_BKUP:  ram_nxt = pd_arm_r;
          CLS_PD_ARM:    pd_arm_nxt = 1'b1;
          CLS_WAKE_SKIP: skip_nxt = wakeup_flag;
          CLS_WDT_CLR: begin
            if (wdt_flag_r) begin
              wdt_flag_nxt = 1'b0;
              skip_nxt     = 1'b1;
            end
            if (wdt_arm_r)
              wdt_stop_nxt = 1'b1;
          end
          CLS_WDT_ARM:   wdt_arm_nxt = 1'b1;
          CLS_HB_CLR:    hb_flag_nxt = 1'b0;
          CLS_HB_SET:    hb_flag_nxt = 1'b1;
          CLS_LVD_KEEP:  lvd_nxt = 1'b1;
          CLS_CLK_MODE:  clk_mode_nxt = acc_value;
          CLS_CLK_SEL:   clk_sel_nxt = acc_value;
          CLS_TABLE: begin
            tab_v_nxt    = 1'b1;
            tab_page_nxt = instr_word[5:0];
          end
          CLS_PAGE_CALL, CLS_PAGE_JMP: begin
            br_v_nxt    = 1'b1;
            br_long_nxt = 1'b0;
            br_call_nxt = (cls == CLS_PAGE_CALL);
            br_addr_nxt = instr_word[6:0];
          end
          CLS_LONG_JMP, CLS_LONG_CALL, CLS_JMP_IND, CLS_CALL_IND, CLS_SEA, CLS_PORTD: begin
            second_nxt    = 1'b1;
            discard_nxt   = 1'b0;
            first_cls_nxt = cls;
            first_low_nxt = instr_word[4:0];
          end
          default: begin
            // unlisted codes advance the program counter and cancel a pending power-down or watchdog arm
          end
        endcase
      end
    end
    // a flag raised in the clearing cycle survives
    if (watchdog_flag_set)
      wdt_flag_nxt = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_mode_r  <= CLOCK_RESET;
      clk_sel_r   <= CLOCK_RESET;
      pd_arm_r    <= 1'b0;
      wdt_arm_r   <= 1'b0;
      wdt_flag_r  <= 1'b0;
      wdt_stop_r  <= 1'b0;
      hb_flag_r   <= 1'b0;
      lvd_r       <= 1'b0;
      skip_r      <= 1'b0;
      second_r    <= 1'b0;
      discard_r   <= 1'b0;
      first_cls_r <= CLS_NOP;
      first_low_r <= 5'h00;
      last_r      <= 10'h000;
      pc_inc_r    <= 1'b0;
      clk_op_r    <= 1'b0;
      ram_r       <= 1'b0;
      sysrst_r    <= 1'b0;
      br_v_r      <= 1'b0;
      br_call_r   <= 1'b0;
      br_long_r   <= 1'b0;
      br_page_r   <= 7'h00;
      br_addr_r   <= 7'h00;
      tab_v_r     <= 1'b0;
      tab_page_r  <= 6'h00;
      cmp_v_r     <= 1'b0;
      cmp_imm_r   <= 4'h0;
      pd_v_r      <= 1'b0;
    end else begin
      clk_mode_r  <= clk_mode_nxt;
      clk_sel_r   <= clk_sel_nxt;
      pd_arm_r    <= pd_arm_nxt;
      wdt_arm_r   <= wdt_arm_nxt;
      wdt_flag_r  <= wdt_flag_nxt;
      wdt_stop_r  <= wdt_stop_nxt;
      hb_flag_r   <= hb_flag_nxt;
      lvd_r       <= lvd_nxt;
      skip_r      <= skip_nxt;
      second_r    <= second_nxt;
      discard_r   <= discard_nxt;
      first_cls_r <= first_cls_nxt;
      first_low_r <= first_low_nxt;
      last_r      <= last_nxt;
      pc_inc_r    <= pc_inc_nxt;
      clk_op_r    <= clk_op_nxt;
      ram_r       <= ram_nxt;
      sysrst_r    <= sysrst_nxt;
      br_v_r      <= br_v_nxt;
      br_call_r   <= br_call_nxt;
      br_long_r   <= br_long_nxt;
      br_page_r   <= br_page_nxt;
      br_addr_r   <= br_addr_nxt;
      tab_v_r     <= tab_v_nxt;
      tab_page_r  <= tab_page_nxt;
      cmp_v_r     <= cmp_v_nxt;
      cmp_imm_r   <= cmp_imm_nxt;
      pd_v_r      <= pd_v_nxt;
    end
  end

  // bus: zero wait states, read data fetched in the address phase
  always_comb begin
    config_nxt  = config_r;
    wr_pend_nxt = bus_go && hwrite;
    wr_addr_nxt = bus_go ? haddr[3:0] : wr_addr_r;
    rdata_nxt   = rdata_r;
    if (wr_pend_r && wr_addr_r == REG_CONFIG)
      config_nxt = hwdata[1:0];
    if (bus_go && !hwrite) begin
      case (haddr[3:0])
        REG_CONFIG: rdata_nxt = {30'h0, config_r};
        REG_STATUS: rdata_nxt = {24'h0, second_r, skip_r, lvd_r, wdt_stop_r,
                                 wdt_arm_r, pd_arm_r, hb_flag_r, wdt_flag_r};
        REG_CLOCK:  rdata_nxt = {24'h0, clk_sel_r, clk_mode_r};
        REG_LAST:   rdata_nxt = {22'h0, last_r};
        default:    rdata_nxt = 32'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_r  <= CONFIG_RESET;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 4'h0;
      rdata_r   <= 32'h0;
    end else begin
      config_r  <= config_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // constant bus answers held in flops so every output leaves a register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign hrdata                     = rdata_r;
  assign pc_inc                     = pc_inc_r;
  assign clock_mode_reg             = clk_mode_r;
  assign clock_select_reg           = clk_sel_r;
  assign enter_clock_operating_mode = clk_op_r;
  assign enter_ram_backup_mode      = ram_r;
  assign software_system_reset      = sysrst_r;
  assign watchdog_flag              = wdt_flag_r;
  assign watchdog_stop              = wdt_stop_r;
  assign high_bit_ref_enable_flag   = hb_flag_r;
  assign low_voltage_detect_keep    = lvd_r;
  assign skip_next                  = skip_r;
  assign branch_valid               = br_v_r;
  assign branch_call                = br_call_r;
  assign branch_long                = br_long_r;
  assign branch_page                = br_page_r;
  assign branch_addr                = br_addr_r;
  assign table_ref_valid            = tab_v_r;
  assign table_page                 = tab_page_r;
  assign acc_compare_valid          = cmp_v_r;
  assign acc_compare_imm            = cmp_imm_r;
  assign port_d_skip_valid          = pd_v_r;
endmodule
`default_nettype wire

// *** cpu_opcode_decode_ctrl_chk.sv ***
// assertion checker for the opcode decoder's instruction results
`default_nettype none
module cpu_opcode_decode_ctrl_chk
  import opcode_decode_pkg::*;
(
  // clock and reset
  input wire logic       hclk,
  input wire logic       hresetn,
  // instruction side
  input wire logic [9:0] instr_word,
  input wire logic       instr_valid,
  input wire logic [3:0] acc_value,
  input wire logic       wakeup_flag,
  input wire logic       watchdog_flag_set,
  // results
  input wire logic       pc_inc,
  input wire logic [3:0] clock_mode_reg,
  input wire logic [3:0] clock_select_reg,
  input wire logic       enter_clock_operating_mode,
  input wire logic       enter_ram_backup_mode,
  input wire logic       watchdog_flag,
  input wire logic       watchdog_stop,
  input wire logic       high_bit_ref_enable_flag,
  input wire logic       skip_next
);
  logic sec_r, drop_r, pd_arm_r, wd_arm_r, two_w, first_w;
  // a word decodes as an opcode only when no second word or skip swallows it
  assign two_w = (instr_word[9:6] == 4'h3) || (instr_word == OP_JMP_IND) || (instr_word == OP_CALL_IND) ||
                 (instr_word == OP_SEA) || (instr_word == OP_PORTD);
  assign first_w = instr_valid && !sec_r && !drop_r && !skip_next;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_r    <= 1'b0;
      drop_r   <= 1'b0;
      pd_arm_r <= 1'b0;
      wd_arm_r <= 1'b0;
    end else if (instr_valid) begin
      sec_r    <= first_w && two_w;
      drop_r   <= !sec_r && !drop_r && skip_next && two_w;
      pd_arm_r <= first_w && (instr_word == OP_PD_ARM);
      wd_arm_r <= first_w && (instr_word == OP_WDT_ARM);
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_clk_mode;
    first_w && instr_word == OP_CLK_MODE |=> clock_mode_reg == $past(acc_value);
  endproperty
  a_clk_mode: assert property (p_clk_mode) else $error("clock mode not loaded");
  property p_clk_sel;
    first_w && instr_word == OP_CLK_SEL |=> clock_select_reg == $past(acc_value);
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock select not loaded");
  property p_nop;
    first_w && (instr_word == OP_NOP || instr_word == 10'h009) |=>
      pc_inc && $stable(clock_mode_reg) && $stable(high_bit_ref_enable_flag) && !skip_next;
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state");
  property p_pc;
    instr_valid |=> pc_inc;
  endproperty
  a_pc: assert property (p_pc) else $error("program counter not advanced");
  property p_clk_op;
    first_w && instr_word == OP_CLK_OP |=> enter_clock_operating_mode == $past(pd_arm_r);
  endproperty
  a_clk_op: assert property (p_clk_op) else $error("clock operating entry wrong");
  property p_ram;
    first_w && instr_word == OP_RAM_BKUP |=> enter_ram_backup_mode == $past(pd_arm_r);
  endproperty
  a_ram: assert property (p_ram) else $error("ram back-up entry wrong");
  property p_wake;
    first_w && instr_word == OP_WAKE_SKIP |=> skip_next == $past(wakeup_flag);
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup skip wrong");
  property p_wdt;
    first_w && instr_word == OP_WDT_CLR && !watchdog_flag_set |=> !watchdog_flag && skip_next == $past(watchdog_flag);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog clear wrong");
  property p_wstop;
    first_w && instr_word == OP_WDT_CLR |=> watchdog_stop == ($past(watchdog_stop) || $past(wd_arm_r));
  endproperty
  a_wstop: assert property (p_wstop) else $error("watchdog stop wrong");
  property p_hb;
    first_w && (instr_word == OP_HB_SET || instr_word == OP_HB_CLR) |=> high_bit_ref_enable_flag == $past(instr_word[0]);
  endproperty
  a_hb: assert property (p_hb) else $error("high bit flag wrong");
  c_clk_op: cover property (enter_clock_operating_mode);
  c_ram: cover property (enter_ram_backup_mode);
  c_stop: cover property ($rose(watchdog_stop));
endmodule
`default_nettype wire

// *** prog_mem_model.sv ***
// program memory model feeding ten-bit words to the decoder
`default_nettype none
module prog_mem_model (
  // clock
  input  wire logic      hclk,
  // instruction stream
  output var logic [9:0] instr_word,
  output var logic       instr_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    instr_word  = 10'h155;
    instr_valid = 1'b0;
  end
  // back-to-back calls keep the strobe high, one word per cycle
  task automatic issue(input logic [9:0] w);
    @(posedge hclk);
    instr_word  <= w;
    instr_valid <= 1'b1;
  endtask
  // released bus shows the inverse, so a stale word is never mistaken for data
  task automatic rest();
    instr_valid <= 1'b0;
    instr_word  <= ~instr_word;
  endtask
endmodule
`default_nettype wire

// *** test_cpu_opcode_decode_ctrl.sv ***
// self-checking testbench for the opcode decoder
`default_nettype none
module test_cpu_opcode_decode_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import opcode_decode_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, instr_valid, wakeup_flag, watchdog_flag_set;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [9:0]  instr_word;
  logic [3:0]  acc_value, clock_mode_reg, clock_select_reg, acc_compare_imm;
  logic        pc_inc, enter_clock_operating_mode, enter_ram_backup_mode, software_system_reset, watchdog_flag;
  logic        watchdog_stop, high_bit_ref_enable_flag, low_voltage_detect_keep, skip_next, branch_valid;
  logic        branch_call, branch_long, table_ref_valid, acc_compare_valid, port_d_skip_valid;
  logic [6:0]  branch_page, branch_addr;
  logic [5:0]  table_page;
  int          error_cnt = 0;
  int          samples_checked = 0;
  cpu_opcode_decode_ctrl uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .instr_word, .instr_valid, .acc_value, .wakeup_flag, .watchdog_flag_set, .pc_inc,
    .clock_mode_reg, .clock_select_reg, .enter_clock_operating_mode, .enter_ram_backup_mode, .software_system_reset,
    .watchdog_flag, .watchdog_stop, .high_bit_ref_enable_flag, .low_voltage_detect_keep, .skip_next, .branch_valid,
    .branch_call, .branch_long, .branch_page, .branch_addr, .table_ref_valid, .table_page, .acc_compare_valid,
    .acc_compare_imm, .port_d_skip_valid);
  prog_mem_model pm (.hclk, .instr_word, .instr_valid);
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  // let the last word be taken, then look at its results
  task automatic fin();
    @(posedge hclk);
    pm.rest();
    watchdog_flag_set <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (3000) @(posedge hclk);
    error_cnt++;
    complete_run();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    acc_value = 4'h0;
    wakeup_flag = 1'b0;
    watchdog_flag_set = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h0, 32'h0);
    check(rd, 32'h3);
    bus(1'b0, 32'h4, 32'h0);
    check(rd, 32'h0);
    pm.issue(OP_CLK_MODE);
    acc_value <= 4'h5;
    pm.issue(OP_CLK_SEL);
    acc_value <= 4'ha;
    pm.issue(OP_NOP);
    acc_value <= 4'h3;
    pm.issue(10'h009);
    fin();
    check(32'({clock_select_reg, clock_mode_reg}), 32'ha5);
    for (int i = 0; i < 4; i++) begin
      if (i != 3) pm.issue(OP_PD_ARM);
      if (i == 1) pm.issue(OP_NOP);
      pm.issue(i < 2 ? OP_CLK_OP : OP_RAM_BKUP);
      fin();
      check(32'({enter_clock_operating_mode, enter_ram_backup_mode}), 32'({i == 0, i == 2}));
    end
    for (int i = 0; i < 2; i++) begin
      pm.issue(OP_WAKE_SKIP);
      wakeup_flag <= 1'(i);
      acc_value   <= 4'(6 * i + 3);
      pm.issue(OP_CLK_MODE);
      fin();
      check(32'({skip_next, clock_mode_reg}), 32'h03);
    end
    pm.issue(OP_NOP);
    watchdog_flag_set <= 1'b1;
    pm.issue(OP_WDT_CLR);
    watchdog_flag_set <= 1'b0;
    fin();
    check(32'({watchdog_flag, skip_next, watchdog_stop}), 32'h2);
    pm.issue(OP_NOP);
    pm.issue(OP_WDT_ARM);
    pm.issue(OP_WDT_CLR);
    fin();
    check(32'({watchdog_flag, skip_next, watchdog_stop}), 32'h1);
    for (int i = 1; i >= 0; i--) begin
      pm.issue(i == 1 ? OP_HB_SET : OP_HB_CLR);
      fin();
      check(32'(high_bit_ref_enable_flag), 32'(i));
    end
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, 32'h0, 32'(3 * i));
      pm.issue(OP_LVD_KEEP);
      pm.issue(10'h0a5);
      fin();
      check(32'({low_voltage_detect_keep, table_ref_valid}), 32'(3 * i));
    end
    check(32'(table_page), 32'h25);
    pm.issue(10'h0d2);
    pm.issue(10'h2c5);
    fin();
    check(32'({branch_valid, branch_call, branch_long, branch_page, branch_addr}), 32'h1d945);
    pm.issue(10'h105);
    fin();
    check(32'({branch_valid, branch_call, branch_long}), 32'h6);
    pm.issue(OP_SEA);
    pm.issue(10'h07c);
    fin();
    check(32'({acc_compare_valid, acc_compare_imm}), 32'h1c);
    pm.issue(OP_PORTD);
    pm.issue(PORTD_W2);
    fin();
    check(32'({port_d_skip_valid, acc_compare_imm}), 32'h1c);
    pm.issue(OP_SYS_RESET);
    fin();
    check(32'({hresp, hreadyout, software_system_reset}), 32'h3);
    bus(1'b0, 32'h8, 32'h0);
    check(rd, 32'ha3);
    complete_run();
  end
endmodule
bind cpu_opcode_decode_ctrl cpu_opcode_decode_ctrl_chk chk (.hclk, .hresetn, .instr_word, .instr_valid, .acc_value,
  .wakeup_flag, .watchdog_flag_set, .pc_inc, .clock_mode_reg, .clock_select_reg, .enter_clock_operating_mode,
  .enter_ram_backup_mode, .watchdog_flag, .watchdog_stop, .high_bit_ref_enable_flag, .skip_next);
`default_nettype wire
